// file: hw/ina_pkg.sv
// Behaviour
// - packets already in execute phase one run on through phase five
// - packets not yet in execute phase one are annulled and refetched
// - refetched code sees pre-entry results with no delay slots left
// - urgent interrupt is taken in a maskable handler, enable clear or not
// - inside the urgent handler no urgent or maskable interrupt is taken
// - setting the global enable in a maskable handler re-admits maskable requests
// - nesting overwrites previous enable; both bits written separately
// - both return pointers are readable and writable by software
// - maskable entry saves then clears global enable; urgent clears its own
// - first annulled packet address goes to the matching return pointer
package ina_pkg;
  localparam int ADDR_W         = 32;
  localparam int CSR_W          = 32;
  localparam int CSR_GEN_BIT    = 0;
  localparam int CSR_PREV_BIT   = 1;
  localparam int EXEC_DEPTH     = 5;
  localparam int NUM_MASKABLE   = 12;
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    INA_SEL_CSR  = 2'b00,
    INA_SEL_IRP  = 2'b01,
    INA_SEL_UPTR = 2'b10,
    INA_SEL_UEN  = 2'b11
  } ina_sel_t;
endpackage : ina_pkg

// file: hw/ina_exec_pipe.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// execute-phase tracker: packets in e1..e5 always drain, never annulled
module ina_exec_pipe #(
  parameter int DEPTH = ina_pkg::EXEC_DEPTH
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic e1_issue,
  output logic      e5_retire,
  output logic      busy
);
  // a single stage leaves no shift path to build
  if (DEPTH < 2) begin : g_bad
    $error("depth must be at least two");
  end
  logic [DEPTH-1:0] stage_r;
  logic [DEPTH-1:0] stage_nxt;
  assign stage_nxt = {stage_r[DEPTH-2:0], e1_issue};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stage_r <= '0;
    else stage_r <= stage_nxt;
  end
  assign e5_retire = stage_r[DEPTH-1];
  assign busy      = |stage_r;
endmodule : ina_exec_pipe

// file: hw/ina_core.sv
`timescale 1ns/100ps
module ina_core #(
  parameter int NUM_MASKABLE = ina_pkg::NUM_MASKABLE
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // interrupt sources, already flagged and unmasked per line
  input  wire logic [NUM_MASKABLE-1:0]     maskable_irq_lines,
  input  wire logic                        urgent_irq,
  // pipeline side
  input  wire logic                        e1_issue,
  input  wire logic [ina_pkg::ADDR_W-1:0]  next_packet_addr,
  input  wire logic                        return_maskable,
  input  wire logic                        return_urgent,
  // control register port from the move-to-control path
  input  wire logic                        ctl_wr,
  input  wire ina_pkg::ina_sel_t           ctl_sel,
  input  wire logic [31:0]                 ctl_wdata,
  output logic      [31:0]                 ctl_rdata,
  // entry outcome
  output logic                             take_maskable,
  output logic                             take_urgent,
  output logic                             annul_fetch,
  output logic                             e5_retire,
  output logic                             global_irq_enable,
  output logic                             previous_global_enable,
  output logic                             urgent_irq_enable,
  output logic      [ina_pkg::ADDR_W-1:0]  maskable_return_pointer,
  output logic      [ina_pkg::ADDR_W-1:0]  urgent_return_pointer
);
  if (NUM_MASKABLE < 1 || NUM_MASKABLE > ina_pkg::NUM_MASKABLE) begin : g_bad
    $error("maskable line count out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  logic                       glob_en_r, prev_en_r, urg_en_r, in_urgent_r;
  logic [ina_pkg::ADDR_W-1:0] irp_r, urg_ptr_r;
  logic                       pipe_busy;
  logic                       issue_kept;

  ina_exec_pipe #(.DEPTH(ina_pkg::EXEC_DEPTH)) u_pipe (
    .clk       (clk),
    .reset_n   (reset_n),
    .e1_issue  (issue_kept),
    .e5_retire (e5_retire),
    .busy      (pipe_busy)
  );

  // urgent needs its own enable only; the global enable plays no part
  wire any_mask = |maskable_irq_lines;
  assign take_urgent   = urgent_irq & urg_en_r & ~in_urgent_r;
  assign take_maskable = any_mask & glob_en_r & urg_en_r & ~in_urgent_r
                         & ~take_urgent;
  // packets not yet in e1 are dropped; fetch restarts at the saved pointer
  assign annul_fetch = take_urgent | take_maskable;
  // a packet offered in the entry cycle is the first annulled one
  assign issue_kept  = e1_issue & ~annul_fetch;

  wire wr_csr     = ctl_wr & (ctl_sel == ina_pkg::INA_SEL_CSR);
  wire wr_irp     = ctl_wr & (ctl_sel == ina_pkg::INA_SEL_IRP);
  wire wr_urg_ptr = ctl_wr & (ctl_sel == ina_pkg::INA_SEL_UPTR);
  wire wr_urg_en  = ctl_wr & (ctl_sel == ina_pkg::INA_SEL_UEN);

  ////////////////////////////////////////////////////////////////////////////
  // entry wins over a same-cycle software write so the hardware save holds
  logic glob_en_nxt, prev_en_nxt, urg_en_nxt;
  assign glob_en_nxt = take_maskable ? 1'b0 :
                       wr_csr ? ctl_wdata[ina_pkg::CSR_GEN_BIT] :
                       glob_en_r;
  assign prev_en_nxt = take_maskable ? glob_en_r :
                       wr_csr ? ctl_wdata[ina_pkg::CSR_PREV_BIT] :
                       prev_en_r;
  // software may only set the urgent enable, so no handler can lose it
  assign urg_en_nxt  = take_urgent ? 1'b0 :
                       (return_urgent | (wr_urg_en & ctl_wdata[0])) ? 1'b1 :
                       urg_en_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      glob_en_r <= 1'b0;
      prev_en_r <= 1'b0;
      urg_en_r  <= 1'b0;
    end else begin
      glob_en_r <= glob_en_nxt;
      prev_en_r <= prev_en_nxt;
      urg_en_r  <= urg_en_nxt;
    end
  end

  // urgent handler lasts from entry until the urgent return pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) in_urgent_r <= 1'b0;
    else if (take_urgent) in_urgent_r <= 1'b1;
    else if (return_urgent) in_urgent_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irp_r     <= ina_pkg::PTR_RESET;
      urg_ptr_r <= ina_pkg::PTR_RESET;
    end else begin
      if (take_maskable) irp_r <= next_packet_addr;
      else if (wr_irp) irp_r <= ctl_wdata;
      if (take_urgent) urg_ptr_r <= next_packet_addr;
      else if (wr_urg_ptr) urg_ptr_r <= ctl_wdata;
    end
  end

  wire [31:0] csr_word = {{(ina_pkg::CSR_W-2){1'b0}},
                          prev_en_r, glob_en_r};
  assign ctl_rdata = (ctl_sel == ina_pkg::INA_SEL_CSR)  ? csr_word :
                     (ctl_sel == ina_pkg::INA_SEL_IRP)  ? irp_r :
                     (ctl_sel == ina_pkg::INA_SEL_UPTR) ? urg_ptr_r :
                     {{31{1'b0}}, urg_en_r};

  assign global_irq_enable       = glob_en_r;
  assign previous_global_enable  = prev_en_r;
  assign urgent_irq_enable       = urg_en_r;
  assign maskable_return_pointer = irp_r;
  assign urgent_return_pointer   = urg_ptr_r;

  ////////////////////////////////////////////////////////////////////////////
  property p_maskable_saves;
    @(posedge clk) disable iff (!reset_n)
    take_maskable |=> !glob_en_r && (prev_en_r == $past(glob_en_r));
  endproperty
  a_maskable_saves: assert property (p_maskable_saves)
    else $error("maskable entry did not save and clear enable");
  property p_urgent_clears;
    @(posedge clk) disable iff (!reset_n)
    take_urgent |=> !urg_en_r && in_urgent_r;
  endproperty
  a_urgent_clears: assert property (p_urgent_clears)
    else $error("urgent entry did not clear its enable");
  property p_irp_load;
    @(posedge clk) disable iff (!reset_n)
    take_maskable |=> irp_r == $past(next_packet_addr);
  endproperty
  a_irp_load: assert property (p_irp_load)
    else $error("maskable return pointer not loaded");
  property p_uptr_load;
    @(posedge clk) disable iff (!reset_n)
    take_urgent && !wr_irp |=> urg_ptr_r == $past(next_packet_addr)
      && irp_r == $past(irp_r);
  endproperty
  a_uptr_load: assert property (p_uptr_load)
    else $error("urgent return pointer not loaded");
  property p_no_nest_urgent;
    @(posedge clk) disable iff (!reset_n)
    in_urgent_r |-> !take_urgent && !take_maskable;
  endproperty
  a_no_nest_urgent: assert property (p_no_nest_urgent)
    else $error("interrupt taken inside urgent handler");
  property p_urgent_ignores_glob;
    @(posedge clk) disable iff (!reset_n)
    urgent_irq && urg_en_r && !in_urgent_r && !glob_en_r |-> take_urgent;
  endproperty
  a_urgent_ignores_glob: assert property (p_urgent_ignores_glob)
    else $error("urgent interrupt refused with enable clear");
  property p_glob_nest;
    @(posedge clk) disable iff (!reset_n)
    any_mask && glob_en_r && urg_en_r && !in_urgent_r && !urgent_irq
      |-> take_maskable;
  endproperty
  a_glob_nest: assert property (p_glob_nest)
    else $error("enabled maskable interrupt not taken");
  property p_drain;
    @(posedge clk) disable iff (!reset_n)
    issue_kept |-> ##5 e5_retire;
  endproperty
  a_drain: assert property (p_drain)
    else $error("issued packet did not retire at fifth phase");
  property p_csr_sep;
    @(posedge clk) disable iff (!reset_n)
    wr_csr && !take_maskable |=>
      glob_en_r == $past(ctl_wdata[ina_pkg::CSR_GEN_BIT]) &&
      prev_en_r == $past(ctl_wdata[ina_pkg::CSR_PREV_BIT]);
  endproperty
  a_csr_sep: assert property (p_csr_sep)
    else $error("control status write lost");
  property p_urgent_refused;
    @(posedge clk) disable iff (!reset_n)
    !urg_en_r || in_urgent_r |-> !take_urgent;
  endproperty
  a_urgent_refused: assert property (p_urgent_refused)
    else $error("urgent interrupt taken while refused");
  property p_mask_refused;
    @(posedge clk) disable iff (!reset_n)
    !glob_en_r |-> !take_maskable;
  endproperty
  a_mask_refused: assert property (p_mask_refused)
    else $error("maskable interrupt taken with enable clear");
  property p_urgent_return;
    @(posedge clk) disable iff (!reset_n)
    return_urgent && !take_urgent |=> urg_en_r && !in_urgent_r;
  endproperty
  a_urgent_return: assert property (p_urgent_return)
    else $error("urgent return did not reopen interrupts");
  property p_irp_write;
    @(posedge clk) disable iff (!reset_n)
    wr_irp && !take_maskable |=> irp_r == $past(ctl_wdata);
  endproperty
  a_irp_write: assert property (p_irp_write)
    else $error("maskable return pointer write lost");
  property p_uptr_write;
    @(posedge clk) disable iff (!reset_n)
    wr_urg_ptr && !take_urgent |=> urg_ptr_r == $past(ctl_wdata);
  endproperty
  a_uptr_write: assert property (p_uptr_write)
    else $error("urgent return pointer write lost");
  property p_csr_read;
    @(posedge clk) disable iff (!reset_n)
    ctl_sel == ina_pkg::INA_SEL_CSR
      |-> ctl_rdata[ina_pkg::CSR_GEN_BIT] == glob_en_r;
  endproperty
  a_csr_read: assert property (p_csr_read)
    else $error("global enable not in bit zero of read word");
  property p_retire_kept;
    @(posedge clk) disable iff (!reset_n)
    e5_retire |-> $past(issue_kept, 5);
  endproperty
  a_retire_kept: assert property (p_retire_kept)
    else $error("annulled packet retired");
  property p_idle_quiet;
    @(posedge clk) disable iff (!reset_n)
    !pipe_busy |=> !e5_retire;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("retire seen from an empty pipeline");
endmodule : ina_core

// file: dv/ina_pipe_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// pipeline stand-in: a refused packet never enters execute phase one
module ina_pipe_model (
  input  wire logic        issue_req,
  input  wire logic [31:0] addr_req,
  input  wire logic        annul_fetch,
  output logic             e1_issue,
  output logic      [31:0] next_packet_addr
);
  assign e1_issue         = issue_req & ~annul_fetch;
  assign next_packet_addr = addr_req;
endmodule : ina_pipe_model

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic        clk = 0, reset_n = 0, urg = 0, iss = 0, wr = 0, ret_u = 0;
  logic [11:0] lines = '0;
  logic [31:0] addr = '0, wd = '0, seed = 32'h9f89_8331;
  logic [31:0] a0, a1, rd, irp, uptr, na;
  logic        tm, tu, an, e5, gen, pgen, uen, e1;
  ina_pkg::ina_sel_t sel = ina_pkg::INA_SEL_CSR;
  int          mismatches = 0, comparisons = 0, cyc = 0, qk[$];
  logic [31:0] qv[$];
  string       nm[10] = '{"ctl_rdata", "maskable_return_pointer",
    "urgent_return_pointer", "take_maskable", "take_urgent",
    "global_irq_enable", "previous_global_enable", "urgent_irq_enable",
    "e5_retire", "annul_fetch"};
  always #5 clk = ~clk;
  ina_pipe_model ina_pipe_model_i (.issue_req(iss), .addr_req(addr),
    .annul_fetch(an), .e1_issue(e1), .next_packet_addr(na));
  ina_core ina_core_i (.clk(clk), .reset_n(reset_n),
    .maskable_irq_lines(lines), .urgent_irq(urg), .e1_issue(e1),
    .next_packet_addr(na), .return_maskable(1'b0), .return_urgent(ret_u),
    .ctl_wr(wr), .ctl_sel(sel), .ctl_wdata(wd), .ctl_rdata(rd),
    .take_maskable(tm), .take_urgent(tu), .annul_fetch(an),
    .e5_retire(e5), .global_irq_enable(gen), .previous_global_enable(pgen),
    .urgent_irq_enable(uen), .maskable_return_pointer(irp),
    .urgent_return_pointer(uptr));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] obs(int k);
    logic [6:0] f;
    f = {an, e5, uen, pgen, gen, tu, tm};
    if (k == 0) return rd;
    if (k == 1) return irp;
    if (k == 2) return uptr;
    return {31'h0, f[k-3]};
  endfunction : obs
  task automatic ex(int k, logic [31:0] e);
    qk.push_back(k);
    qv.push_back(e);
  endtask : ex
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // wr drops for a full cycle so back-to-back calls never re-drive it
  task automatic wrt(ina_pkg::ina_sel_t s, logic [31:0] d);
    sel = s;
    wd = d;
    wr = 1;
    tick();
    wr = 0;
    tick();
  endtask : wrt
  task automatic rdc(ina_pkg::ina_sel_t s, logic [31:0] e);
    sel = s;
    ex(0, e);
    tick();
  endtask : rdc
  task automatic irq(logic u);
    a0 = xs();
    a1 = xs();
    addr = a0;
    urg = u;
    lines = u ? 12'h000 : (a1[11:0] | 12'h001);
  endtask : irq
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  // watcher: compare settled outputs mid-cycle, oldest note first
  always @(negedge clk) begin
    while (qk.size() > 0) begin
      comparisons++;
      if (obs(qk[0]) !== qv[0]) begin
        mismatches++;
        $display("mismatch %s exp %h got %h", nm[qk[0]], qv[0], obs(qk[0]));
      end
      void'(qk.pop_front());
      void'(qv.pop_front());
    end
  end
  // the test runs under 50 cycles, far less than the 2000-cycle limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1;
    tick();
    rdc(ina_pkg::INA_SEL_UPTR, 0);
    wrt(ina_pkg::INA_SEL_UEN, 1);
    wrt(ina_pkg::INA_SEL_CSR, 1);
    rdc(ina_pkg::INA_SEL_CSR, 1);
    irq(0);
    ex(3, 1);
    ex(9, 1);
    tick();
    ex(5, 0);
    ex(6, 1);
    ex(1, a0);
    irq(1);
    ex(4, 1);
    tick();
    ex(7, 0);
    ex(2, a0);
    ex(4, 0);
    wrt(ina_pkg::INA_SEL_CSR, 1);
    irq(0);
    ex(3, 0);
    tick();
    lines = '0;
    ret_u = 1;
    tick();
    ret_u = 0;
    irq(0);
    ex(3, 1);
    tick();
    lines = '0;
    ex(6, 1);
    ex(1, a0);
    wrt(ina_pkg::INA_SEL_CSR, 2);
    rdc(ina_pkg::INA_SEL_CSR, 2);
    wrt(ina_pkg::INA_SEL_CSR, 1);
    rdc(ina_pkg::INA_SEL_CSR, 1);
    for (int i = 1; i < 3; i++) begin
      a0 = xs();
      wrt(ina_pkg::ina_sel_t'(i), a0);
      rdc(ina_pkg::ina_sel_t'(i), a0);
    end
    iss = 1;
    tick();
    irq(1);
    ex(4, 1);
    tick();
    iss = 0;
    urg = 0;
    repeat (3) tick();
    ex(8, 1);
    tick();
    ex(8, 0);
    tick();
    tally_and_finish();
  end
endmodule : tb
